// ==== common/fetx_consts.vh ====
`ifndef FETX_CONSTS_VH
`define FETX_CONSTS_VH
`define FETX_CG_IDLE 5'h1f
`define FETX_CG_J 5'h18
`define FETX_CG_K 5'h11
`define FETX_CG_T 5'h0d
`define FETX_CG_R 5'h07
`define FETX_LFSR_W 11
`define FETX_LFSR_RST 11'h7ff
`define FETX_SEED_LO 4'h0
`define FETX_SEED_HI 3'h7
`define FETX_PRE_NIB 2
`endif

// ==== hdl/fetx_line_coder.v ====
`timescale 1ns/1ps
`include "fetx_consts.vh"
//
// Behaviour
// - each 4-bit transmit nibble becomes a 5-bit code-group.
// - first two preamble nibbles are replaced by code-groups 11000 then 10001.
// - remaining preamble and data nibbles map through the 4B5B table.
// - on transmit enable falling, send 01101 then 00111.
// - after end delimiter, send idle code-groups until transmit enable returns.
// - scrambler is an 11-bit closed-loop LFSR.
// - scrambled bit is LFSR output xor serial NRZ bit.
// - scrambler seed derives from port address bits 4 down to 1.
// - scrambled stream is NRZI encoded before driving.
// - MLT-3 stage yields two drive streams with alternating one events.
// - transmit output is MLT-3 only, no binary output offered.
// - signal detect stays low for link pulses alone.
// - receive converts three-level MLT-3 symbols into NRZI bits.
// - receive converts NRZI to NRZ bits.
// - receive deserialises bits into 5-bit symbols.
// - idle code-group is 11111; nibble 0000 maps to 11110.
// - scrambler can be bypassed by an option.
module fetx_line_coder #(
    parameter LFSR_W = `FETX_LFSR_W
)(
    input wire core_clk,
    input wire rst_n,
    input wire tx_en,
    input wire [3:0] txd,
    input wire [4:0] phy_address_pins,
    input wire scram_bypass,
    input wire [1:0] rx_mlt3_sym,
    input wire rx_sd_energy,
    input wire rx_link_pulse_only,
    output reg tx_drive_p,
    output reg tx_drive_n,
    output reg rx_nrz,
    output reg rx_nrz_valid,
    output reg [4:0] rx_symbol,
    output reg rx_symbol_valid,
    output reg sig_detect_100
);

// ==========================================================
// input synchronisers
// ==========================================================
reg en_s1_reg, en_s2_reg;
reg [3:0] d_s1_reg, d_s2_reg;
reg [4:0] ad_s1_reg, ad_s2_reg;
reg [1:0] byp_s_reg;
reg [1:0] sym_s1_reg, sym_s2_reg;
reg [1:0] sd_s_reg, lp_s_reg;
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        en_s1_reg <= 1'b0;
        en_s2_reg <= 1'b0;
        d_s1_reg <= 4'h0;
        d_s2_reg <= 4'h0;
        ad_s1_reg <= 5'h00;
        ad_s2_reg <= 5'h00;
        byp_s_reg <= 2'h0;
        sym_s1_reg <= 2'h0;
        sym_s2_reg <= 2'h0;
        sd_s_reg <= 2'h0;
        lp_s_reg <= 2'h0;
    end
    else
    begin
        en_s1_reg <= tx_en;
        en_s2_reg <= en_s1_reg;
        d_s1_reg <= txd;
        d_s2_reg <= d_s1_reg;
        ad_s1_reg <= phy_address_pins;
        ad_s2_reg <= ad_s1_reg;
        byp_s_reg <= {byp_s_reg[0], scram_bypass};
        sym_s1_reg <= rx_mlt3_sym;
        sym_s2_reg <= sym_s1_reg;
        sd_s_reg <= {sd_s_reg[0], rx_sd_energy};
        lp_s_reg <= {lp_s_reg[0], rx_link_pulse_only};
    end
end
// same two-stage latency as txd, so each nibble meets its own enable
wire en_q = en_s2_reg;

// ==========================================================
// 4b5b table
// ==========================================================
function [4:0] fetx_enc;
    input [3:0] n;
    begin
        case (n)
            4'h0: fetx_enc = 5'h1e;
            4'h1: fetx_enc = 5'h09;
            4'h2: fetx_enc = 5'h14;
            4'h3: fetx_enc = 5'h15;
            4'h4: fetx_enc = 5'h0a;
            4'h5: fetx_enc = 5'h0b;
            4'h6: fetx_enc = 5'h0e;
            4'h7: fetx_enc = 5'h0f;
            4'h8: fetx_enc = 5'h12;
            4'h9: fetx_enc = 5'h13;
            4'ha: fetx_enc = 5'h16;
            4'hb: fetx_enc = 5'h17;
            4'hc: fetx_enc = 5'h1a;
            4'hd: fetx_enc = 5'h1b;
            4'he: fetx_enc = 5'h1c;
            default: fetx_enc = 5'h1d;
        endcase
    end
endfunction

// ==========================================================
// code-group encoder, one group per 5 bit times
// ==========================================================
localparam ST_IDLE = 3'h0;
localparam ST_J = 3'h1;
localparam ST_K = 3'h2;
localparam ST_DATA = 3'h3;
localparam ST_T = 3'h4;
localparam ST_R = 3'h5;
reg [2:0] st_reg, st_next;
reg [2:0] bit_cnt_reg;
reg [4:0] sh_reg;
reg [4:0] cg_next;
wire grp_end = (bit_cnt_reg == 3'h4);
// txd is sampled once per code-group; the mac is assumed to hold nibbles for 5 bit times
always @*
begin
    st_next = st_reg;
    cg_next = `FETX_CG_IDLE;
    case (st_reg)
        ST_IDLE:
        begin
            if (en_q)
            begin
                cg_next = `FETX_CG_J;
                st_next = ST_K;
            end
        end
        ST_J:
        begin
            cg_next = `FETX_CG_J;
            st_next = ST_K;
        end
        ST_K:
        begin
            cg_next = `FETX_CG_K;
            st_next = ST_DATA;
        end
        ST_DATA:
        begin
            if (en_q)
                cg_next = fetx_enc(d_s2_reg);
            else
            begin
                cg_next = `FETX_CG_T;
                st_next = ST_R;
            end
        end
        ST_T:
        begin
            cg_next = `FETX_CG_T;
            st_next = ST_R;
        end
        ST_R:
        begin
            cg_next = `FETX_CG_R;
            st_next = ST_IDLE;
        end
        default:
        begin
            st_next = ST_IDLE;
        end
    endcase
end
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        st_reg <= ST_IDLE;
        bit_cnt_reg <= 3'h0;
        sh_reg <= `FETX_CG_IDLE;
    end
    else if (grp_end)
    begin
        bit_cnt_reg <= 3'h0;
        st_reg <= st_next;
        sh_reg <= cg_next;
    end
    else
    begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        sh_reg <= {sh_reg[3:0], 1'b0};
    end
end
// msb-first serial nrz
wire nrz_bit = sh_reg[4];

// ==========================================================
// scrambler, nrzi and mlt-3 transmit
// ==========================================================
reg [LFSR_W-1:0] lfsr_reg;
reg [1:0] seed_wait_reg;
reg nrzi_reg;
reg [1:0] mlt_phase_reg;
// x^11 + x^9 + 1 closed-loop key stream
wire lfsr_fb = lfsr_reg[10] ^ lfsr_reg[8];
wire scr_bit = byp_s_reg[1] ? nrz_bit : (nrz_bit ^ lfsr_fb);
// mlt-3 steps on each nrzi transition, not on the raw bit
wire nrzi_next = nrzi_reg ^ scr_bit;
wire nrzi_edge = nrzi_next ^ nrzi_reg;
// strap synchroniser needs two edges to fill after reset
// an earlier load would take its reset zeros and every port would share one seed
wire [LFSR_W-1:0] seed = {`FETX_SEED_HI, ad_s2_reg[4:1], `FETX_SEED_LO};
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        lfsr_reg <= `FETX_LFSR_RST;
        seed_wait_reg <= 2'h0;
        nrzi_reg <= 1'b0;
        mlt_phase_reg <= 2'h0;
        tx_drive_p <= 1'b0;
        tx_drive_n <= 1'b0;
    end
    else
    begin
        if (seed_wait_reg != 2'h3)
            seed_wait_reg <= seed_wait_reg + 2'h1;
        if (seed_wait_reg == 2'h2)
            lfsr_reg <= seed;
        else
            lfsr_reg <= {lfsr_reg[LFSR_W-2:0], lfsr_fb};
        if (nrzi_edge)
        begin
            nrzi_reg <= nrzi_next;
            mlt_phase_reg <= mlt_phase_reg + 2'h1;
        end
        // phase 0/2 zero, 1 plus, 3 minus; only mlt-3 is ever driven
        tx_drive_p <= nrzi_edge ? (mlt_phase_reg == 2'h0) : (mlt_phase_reg == 2'h1);
        tx_drive_n <= nrzi_edge ? (mlt_phase_reg == 2'h2) : (mlt_phase_reg == 2'h3);
    end
end

// ==========================================================
// receive decode and deserialise
// ==========================================================
reg [1:0] sym_prev_reg;
reg nrzi_bit_reg;
reg nrzi_prev_reg;
reg [4:0] rx_sh_reg;
reg [2:0] rx_cnt_reg;
reg rx_go_reg;
// symbol coding: 2'h0 zero, 2'h1 plus, 2'h3 minus
always @(posedge core_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        sym_prev_reg <= 2'h0;
        nrzi_bit_reg <= 1'b0;
        nrzi_prev_reg <= 1'b0;
        rx_go_reg <= 1'b0;
        rx_nrz <= 1'b0;
        rx_nrz_valid <= 1'b0;
        rx_sh_reg <= 5'h00;
        rx_cnt_reg <= 3'h0;
        rx_symbol <= 5'h00;
        rx_symbol_valid <= 1'b0;
        sig_detect_100 <= 1'b0;
    end
    else
    begin
        sym_prev_reg <= sym_s2_reg;
        if (sym_s2_reg != sym_prev_reg)
            nrzi_bit_reg <= ~nrzi_bit_reg;
        nrzi_prev_reg <= nrzi_bit_reg;
        rx_go_reg <= 1'b1;
        rx_nrz <= nrzi_bit_reg ^ nrzi_prev_reg;
        rx_nrz_valid <= rx_go_reg;
        rx_symbol_valid <= 1'b0;
        if (rx_nrz_valid)
        begin
            rx_sh_reg <= {rx_sh_reg[3:0], rx_nrz};
            if (rx_cnt_reg == 3'h4)
            begin
                rx_cnt_reg <= 3'h0;
                rx_symbol <= {rx_sh_reg[3:0], rx_nrz};
                rx_symbol_valid <= 1'b1;
            end
            else
                rx_cnt_reg <= rx_cnt_reg + 3'h1;
        end
        // link pulses alone never count as 100 mb/s energy
        sig_detect_100 <= sd_s_reg[1] & ~lp_s_reg[1];
    end
end

endmodule // fetx_line_coder

// ==== tb/fetx_cable_loop.sv ====
`timescale 1ns/1ps
// ==========
// cable looped back to the receiver: plus 01, minus 11, zero 00
module fetx_cable_loop (
    input wire tx_drive_p,
    input wire tx_drive_n,
    output wire [1:0] rx_mlt3_sym
);
    assign rx_mlt3_sym = tx_drive_p ? 2'h1 : (tx_drive_n ? 2'h3 : 2'h0);
endmodule // fetx_cable_loop

// ==== tb/fetx_props.sv ====
`timescale 1ns/1ps
// ==========
// line checks
module fetx_props (
    input wire core_clk,
    input wire rst_n,
    input wire rx_sd_energy,
    input wire rx_link_pulse_only,
    input wire tx_drive_p,
    input wire tx_drive_n,
    input wire rx_nrz_valid,
    input wire rx_symbol_valid,
    input wire sig_detect_100
);
    // remembers the last non-zero line level, 1 = plus
    reg last_pos_reg;
    always @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            last_pos_reg <= 1'b0;
        else if (tx_drive_p || tx_drive_n)
            last_pos_reg <= tx_drive_p;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_drive_excl: assert property (!(tx_drive_p && tx_drive_n))
        else $error("both drive streams high");
    a_plus_alt: assert property ($rose(tx_drive_p) |-> !last_pos_reg)
        else $error("plus level repeated without minus");
    a_minus_alt: assert property ($rose(tx_drive_n) |-> last_pos_reg)
        else $error("minus level repeated without plus");
    a_plus_zero: assert property (tx_drive_p |=> !tx_drive_n)
        else $error("plus stepped straight to minus");
    a_minus_zero: assert property (tx_drive_n |=> !tx_drive_p)
        else $error("minus stepped straight to plus");
    a_sym_spacing: assert property (rx_symbol_valid |=> !rx_symbol_valid [*4] ##1 rx_symbol_valid)
        else $error("symbol strobe not every five bits");
    a_sd_pulse: assert property (rx_link_pulse_only [*4] |-> !sig_detect_100)
        else $error("signal detect on link pulses");
    a_sd_energy: assert property ((rx_sd_energy && !rx_link_pulse_only) [*4] |-> sig_detect_100)
        else $error("signal detect missing");
    a_nrz_hold: assert property (rx_nrz_valid |=> rx_nrz_valid)
        else $error("nrz valid dropped");
endmodule // fetx_props
bind fetx_line_coder fetx_props i_props (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rx_sd_energy(rx_sd_energy),
    .rx_link_pulse_only(rx_link_pulse_only),
    .tx_drive_p(tx_drive_p),
    .tx_drive_n(tx_drive_n),
    .rx_nrz_valid(rx_nrz_valid),
    .rx_symbol_valid(rx_symbol_valid),
    .sig_detect_100(sig_detect_100)
);

// ==== tb/tb_fast_ethernet_tx_line_coder.sv ====
`timescale 1ns/1ps
// ==========
// bench
module tb_fast_ethernet_tx_line_coder;
    reg core_clk, rst_n, tx_en, scram_bypass, rx_sd_energy, rx_link_pulse_only;
    reg [3:0] txd;
    reg [4:0] phy_address_pins;
    wire tx_drive_p, tx_drive_n, rx_nrz, rx_nrz_valid, rx_symbol_valid, sig_detect_100;
    wire [4:0] rx_symbol;
    wire [1:0] rx_mlt3_sym;
    integer bad_count, cmp_count;
    reg [39:0] hist;
    localparam [15:0] frame_nibs = 16'h55a3;
    reg seen_frame;
    fetx_line_coder i_dut (.core_clk(core_clk), .rst_n(rst_n), .tx_en(tx_en), .txd(txd),
        .phy_address_pins(phy_address_pins), .scram_bypass(scram_bypass),
        .rx_mlt3_sym(rx_mlt3_sym), .rx_sd_energy(rx_sd_energy),
        .rx_link_pulse_only(rx_link_pulse_only), .tx_drive_p(tx_drive_p),
        .tx_drive_n(tx_drive_n), .rx_nrz(rx_nrz), .rx_nrz_valid(rx_nrz_valid),
        .rx_symbol(rx_symbol), .rx_symbol_valid(rx_symbol_valid),
        .sig_detect_100(sig_detect_100));
    fetx_cable_loop i_cable (.tx_drive_p(tx_drive_p), .tx_drive_n(tx_drive_n),
        .rx_mlt3_sym(rx_mlt3_sym));
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // idle, J, K, 4'ha, 4'h3, T, R, idle as recovered through the loop
    always @(negedge core_clk)
    begin
        hist <= {hist[38:0], rx_nrz};
        if ({hist[38:0], rx_nrz} === 40'hfe236ab4ff)
            seen_frame <= 1'b1;
    end
    task check(input ok, input [8*24:1] msg);
        cmp_count = cmp_count + 1;
        if (ok !== 1'b1)
        begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t %0s", $time, msg);
        end
    endtask
    task complete_run;
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task do_reset(input [4:0] addr);
        rst_n = 1'b0;
        phy_address_pins = addr;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
    endtask
    task t_sd;
        rx_sd_energy = 1'b1;
        rx_link_pulse_only = 1'b1;
        repeat (6) @(negedge core_clk);
        check(sig_detect_100 === 1'b0, "detect on pulses");
        rx_link_pulse_only = 1'b0;
        repeat (6) @(negedge core_clk);
        check(sig_detect_100 === 1'b1, "detect on energy");
        rx_sd_energy = 1'b0;
        repeat (6) @(negedge core_clk);
        check(sig_detect_100 === 1'b0, "detect without energy");
    endtask
    task t_sym;
        integer i, n;
        n = 0;
        repeat (40) @(negedge core_clk);
        for (i = 0; i < 20; i = i + 1)
        begin
            @(negedge core_clk);
            if (rx_symbol_valid === 1'b1)
            begin
                n = n + 1;
                check(rx_symbol === 5'h1f, "idle symbol");
            end
        end
        check(n == 4, "symbol rate");
    endtask
    // two preamble nibbles are overwritten by J/K, then 4'ha and 4'h3
    task t_frame;
        integer i;
        seen_frame = 1'b0;
        for (i = 0; i < 4; i = i + 1)
        begin
            tx_en = 1'b1;
            txd = frame_nibs[(15 - 4 * i) -: 4];
            repeat (5) @(negedge core_clk);
        end
        tx_en = 1'b0;
        txd = 4'h0;
        for (i = 0; i < 200 && !seen_frame; i = i + 1)
            @(negedge core_clk);
        check(seen_frame === 1'b1, "frame stream");
        if (!seen_frame)
            complete_run;
    endtask
    // same timing after each reset, so only the seed can make the streams differ
    task t_seed;
        reg [39:0] a;
        scram_bypass = 1'b0;
        do_reset(5'h02);
        repeat (60) @(negedge core_clk);
        a = hist;
        do_reset(5'h1c);
        repeat (60) @(negedge core_clk);
        check(a !== hist, "seed unused");
        check(a !== 40'hffffffffff, "idle not scrambled");
    endtask
    initial
    begin
        bad_count = 0;
        cmp_count = 0;
        hist = 40'h0;
        seen_frame = 1'b0;
        tx_en = 1'b0;
        txd = 4'h0;
        scram_bypass = 1'b1;
        rx_sd_energy = 1'b0;
        rx_link_pulse_only = 1'b0;
        do_reset(5'h0a);
        t_sd;
        t_sym;
        t_frame;
        t_seed;
        complete_run;
    end
endmodule // tb_fast_ethernet_tx_line_coder
